// ### omp_defs.svh
`ifndef OMP_DEFS_SVH
`define OMP_DEFS_SVH
// Register byte offsets.
`define OMP_OFF_CLK    8'h00
`define OMP_OFF_RC     8'h04
`define OMP_OFF_XT     8'h08
`define OMP_OFF_STAT   8'h0C
`define OMP_OFF_WAKE   8'h10
// Reset values.
`define OMP_RST_CLK    8'h00
`define OMP_RST_RC     8'h01
`define OMP_RST_XT     8'h00
`define OMP_RST_WAKE   8'h00
// Clock control field positions.
`define OMP_CKS_HI     7
`define OMP_CKS_LO     5
`define OMP_FHS_BIT    3
`define OMP_FSS_BIT    2
`define OMP_FKEEP_BIT  1
`define OMP_SKEEP_BIT  0
// Oscillator control field positions.
`define OMP_FSEL_HI    3
`define OMP_FSEL_LO    2
`define OMP_FLAG_BIT   1
`define OMP_EN_BIT     0
// Status field positions.
`define OMP_PDF_BIT    1
`define OMP_TO_BIT     0
// Select code that picks the low speed clock.
`define OMP_CKS_SLOW   3'h7
`endif

// ### omp_pkg.sv
package omp_pkg;
  // Operating mode of the controller.
  typedef enum logic [3:0] {
    OMP_FAST      = 4'h0,
    OMP_SLOW_WAIT = 4'h1,
    OMP_SLOW      = 4'h2,
    OMP_FAST_WAIT = 4'h3,
    OMP_SLEEP     = 4'h4,
    OMP_STBY_SLOW = 4'h5,
    OMP_STBY_BOTH = 4'h6,
    OMP_STBY_FAST = 4'h7,
    OMP_WAKE      = 4'h8
  } omp_mode_t;
  // Reason for the last wake-up.
  typedef enum logic [1:0] {
    OMP_WK_PIN = 2'h0,
    OMP_WK_IRQ = 2'h1,
    OMP_WK_WDT = 2'h2
  } omp_wake_t;
  // Oscillator enables driven to the analog cells.
  typedef struct packed {
    logic fast_rc;
    logic fast_xt;
    logic slow_rc;
    logic slow_xt;
  } omp_osc_t;
  // Commands to the CPU core.
  typedef struct packed {
    logic run;
    logic resume_next;
    logic int_take;
    logic pc_sp_reset;
    logic wdt_clear;
  } omp_cpu_t;
endpackage

// ### omp_ctrl.sv
// Notes on behaviour
// - select code 111 moves to slow mode.
// - slow source by select bit, wait stable.
// - codes 000-110 return fast, divide 1-64.
// - fast restart shown by stable flags.
// - halt, both keeps 0: sleep.
// - halt, fast 0 slow 1: slow-only standby.
// - halt, both keeps 1: both-clock standby.
// - halt, fast 1 slow 0: fast-only standby.
// - power-down keeps memory, registers, ports.
// - halt sets power-down, clears time-out.
// - halt clears the watchdog counter.
// - wake on pin fall, interrupt, overflow.
// - power-up or watchdog clear clears power-down.
// - overflow wake sets time-out, resets PC/SP.
// - per-pin wake enable; resume after halt.
// - disabled or stack-full interrupt resumes next.
// - enabled interrupt with room takes vector.
// - request already set before halt ignored.
// - resume only after oscillator is stable.
// - stable flag drops then rises on restart.
`include "omp_defs.svh"
module omp_ctrl #(
  parameter int N_IRQ = 8,
  parameter int N_PA  = 8
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             halt_exec,
  input  wire logic             clr_wdt_exec,
  input  wire logic             wdt_overflow,
  input  wire logic [N_IRQ-1:0] int_req,
  input  wire logic [N_IRQ-1:0] int_enable,
  input  wire logic             stack_full,
  input  wire logic [N_PA-1:0]  port_a_in,
  input  wire logic             high_speed_rc_ready,
  input  wire logic             high_speed_crystal_ready,
  input  wire logic             low_speed_rc_ready,
  input  wire logic             low_speed_crystal_ready,
  output omp_pkg::omp_osc_t     osc_en,
  output omp_pkg::omp_cpu_t     cpu_ctl,
  output logic      [2:0]       sys_clk_div_sel,
  output omp_pkg::omp_mode_t    mode
);
  import omp_pkg::*;

  // Power-down mode chosen by the two keep bits at halt.
  function automatic omp_mode_t halt_mode(input logic fk,
                                          input logic sk);
    unique case ({fk, sk})
      2'b00:   halt_mode = OMP_SLEEP;
      2'b01:   halt_mode = OMP_STBY_SLOW;
      2'b11:   halt_mode = OMP_STBY_BOTH;
      2'b10:   halt_mode = OMP_STBY_FAST;
    endcase
  endfunction

  // True for the four power-down modes.
  function automatic logic is_down(input omp_mode_t m);
    is_down = (m == OMP_SLEEP) || (m == OMP_STBY_SLOW) ||
              (m == OMP_STBY_BOTH) || (m == OMP_STBY_FAST);
  endfunction

  // Software registers and status.
  logic [7:0]       clk_q;      // Clock control.
  logic [7:0]       rc_q;       // Fast RC control.
  logic [7:0]       xt_q;       // Fast crystal control.
  logic [N_PA-1:0]  port_a_wake_enable;
  logic             power_down_flag;
  logic             watchdog_timeout_flag;
  logic             internal_rc_stable_flag;
  logic             crystal_stable_flag;
  // Bus pipeline.
  logic             wr_q;
  logic [7:0]       addr_q;
  // Mode machine.
  omp_mode_t        mode_q, mode_d;
  logic [2:0]       sel_q, sel_d;
  omp_wake_t        cause_q, cause_d;
  logic [N_IRQ-1:0] irq_pre_q;  // Requests seen at halt.
  logic [N_IRQ-1:0] irq_wk_q;   // Requests that woke us.
  logic [N_PA-1:0]  pa_q;       // Previous pin levels.
  omp_osc_t         osc_d;
  omp_cpu_t         cpu_d;
  logic             rc_en_q, xt_en_q;

  // Field views.
  wire [2:0] system_clock_select = clk_q[`OMP_CKS_HI:`OMP_CKS_LO];
  wire       fast_source_select  = clk_q[`OMP_FHS_BIT];
  wire       slow_source_select  = clk_q[`OMP_FSS_BIT];
  wire       fast_osc_idle_keep  = clk_q[`OMP_FKEEP_BIT];
  wire       slow_osc_idle_keep  = clk_q[`OMP_SKEEP_BIT];

  // Address phase decode.
  wire       take     = hsel & htrans[1] & hready;
  wire [7:0] a_addr   = haddr[7:0];
  wire       wr_clk   = wr_q && addr_q == `OMP_OFF_CLK;
  wire       wr_rc    = wr_q && addr_q == `OMP_OFF_RC;
  wire       wr_xt    = wr_q && addr_q == `OMP_OFF_XT;
  wire       wr_wake  = wr_q && addr_q == `OMP_OFF_WAKE;
  wire [1:0] rc_fsel  = hwdata[`OMP_FSEL_HI:`OMP_FSEL_LO];
  wire       rc_fchg  = wr_rc &&
                        rc_fsel != rc_q[`OMP_FSEL_HI:`OMP_FSEL_LO];

  // Read mux; unmapped addresses read zero.
  wire [7:0] rd_stat  = {1'b0, mode_q[2:0], 2'b00,
                         power_down_flag, watchdog_timeout_flag};
  wire [7:0] rd_mux   =
    a_addr == `OMP_OFF_CLK  ? {clk_q[7:5], 1'b0, clk_q[3:0]} :
    a_addr == `OMP_OFF_RC   ? {4'h0, rc_q[3:2],
                               internal_rc_stable_flag, rc_q[0]} :
    a_addr == `OMP_OFF_XT   ? {6'h00, crystal_stable_flag,
                               xt_q[0]} :
    a_addr == `OMP_OFF_STAT ? rd_stat :
    a_addr == `OMP_OFF_WAKE ? port_a_wake_enable : 8'h00;

  // Stability of the oscillators that clock each mode.
  wire slow_stable = slow_source_select ? low_speed_crystal_ready
                                        : low_speed_rc_ready;
  wire fast_stable = fast_source_select ? crystal_stable_flag
                                        : internal_rc_stable_flag;
  wire sys_stable  = (sel_q == `OMP_CKS_SLOW) ? slow_stable
                                              : fast_stable;
  wire run_state   = (mode_q == OMP_FAST) || (mode_q == OMP_SLOW);
  wire halt_ok     = halt_exec && run_state;

  // Wake sources, valid only while powered down.
  wire [N_PA-1:0]  pa_fall = pa_q & ~port_a_in &
                             port_a_wake_enable;
  wire [N_IRQ-1:0] irq_new = int_req & ~irq_pre_q;
  wire wk_pin = |pa_fall;
  wire wk_irq = |irq_new;
  wire wake   = is_down(mode_q) &&
                (wk_pin || wk_irq || wdt_overflow);
  wire irq_go = |(irq_wk_q & int_enable) && !stack_full;

  // Next mode, applied clock select and wake reason.
  always_comb begin
    mode_d  = mode_q;
    sel_d   = sel_q;
    cause_d = cause_q;
    unique case (mode_q)
      OMP_FAST: begin
        if (halt_exec) begin
          mode_d = halt_mode(fast_osc_idle_keep,
                             slow_osc_idle_keep);
        end else if (system_clock_select == `OMP_CKS_SLOW) begin
          mode_d = OMP_SLOW_WAIT;
        end else begin
          sel_d = system_clock_select;
        end
      end
      OMP_SLOW_WAIT: begin
        if (system_clock_select != `OMP_CKS_SLOW) begin
          mode_d = OMP_FAST;
        end else if (slow_stable) begin
          mode_d = OMP_SLOW;
          sel_d  = `OMP_CKS_SLOW;
        end
      end
      OMP_SLOW: begin
        if (halt_exec) begin
          mode_d = halt_mode(fast_osc_idle_keep,
                             slow_osc_idle_keep);
        end else if (system_clock_select != `OMP_CKS_SLOW) begin
          mode_d = OMP_FAST_WAIT;
        end
      end
      OMP_FAST_WAIT: begin
        if (system_clock_select == `OMP_CKS_SLOW) begin
          mode_d = OMP_SLOW;
        end else if (fast_stable) begin
          mode_d = OMP_FAST;
          sel_d  = system_clock_select;
        end
      end
      OMP_SLEEP, OMP_STBY_SLOW, OMP_STBY_BOTH, OMP_STBY_FAST: begin
        if (wake) begin
          mode_d  = OMP_WAKE;
          cause_d = wdt_overflow ? OMP_WK_WDT :
                    wk_irq       ? OMP_WK_IRQ : OMP_WK_PIN;
        end
      end
      OMP_WAKE: begin
        if (sys_stable) begin
          mode_d = (sel_q == `OMP_CKS_SLOW) ? OMP_SLOW
                                            : OMP_FAST;
        end
      end
      default: mode_d = OMP_FAST;
    endcase
  end

  // Oscillator enables per mode; the CPU only sees a gate.
  always_comb begin
    osc_d.fast_rc = rc_q[`OMP_EN_BIT] ||
                    (sel_q != `OMP_CKS_SLOW && !fast_source_select);
    osc_d.fast_xt = xt_q[`OMP_EN_BIT] ||
                    (sel_q != `OMP_CKS_SLOW && fast_source_select);
    osc_d.slow_rc = 1'b1;
    osc_d.slow_xt = slow_source_select;
    if (mode_d == OMP_SLEEP || mode_d == OMP_STBY_SLOW) begin
      osc_d.fast_rc = 1'b0;
      osc_d.fast_xt = 1'b0;
    end
    if (mode_d == OMP_SLEEP || mode_d == OMP_STBY_FAST) begin
      osc_d.slow_rc = 1'b0;
      osc_d.slow_xt = 1'b0;
    end
    if (mode_d == OMP_FAST_WAIT || mode_d == OMP_WAKE) begin
      osc_d.fast_rc = osc_d.fast_rc || !fast_source_select;
      osc_d.fast_xt = osc_d.fast_xt || fast_source_select;
    end
    // Clock gate opens only in running modes.
    cpu_d.run = !is_down(mode_d) && mode_d != OMP_WAKE;
    cpu_d.wdt_clear   = halt_ok;
    cpu_d.resume_next = 1'b0;
    cpu_d.int_take    = 1'b0;
    cpu_d.pc_sp_reset = 1'b0;
    if (mode_q == OMP_WAKE && sys_stable) begin
      unique case (cause_q)
        OMP_WK_WDT: cpu_d.pc_sp_reset = 1'b1;
        OMP_WK_IRQ: begin
          cpu_d.int_take    = irq_go;
          cpu_d.resume_next = !irq_go;
        end
        OMP_WK_PIN: cpu_d.resume_next = 1'b1;
        default:    cpu_d.resume_next = 1'b1;
      endcase
    end
  end

  // AHB-Lite slave: zero wait, always OKAY, registered read data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_q      <= take & hwrite;
      addr_q    <= a_addr;
      hreadyout <= 1'b1;
      if (take && !hwrite) begin
        hrdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Software registers. Memory, registers and ports outside are
  // untouched by mode changes; only the clock is gated.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_q              <= `OMP_RST_CLK;
      rc_q               <= `OMP_RST_RC;
      xt_q               <= `OMP_RST_XT;
      port_a_wake_enable <= `OMP_RST_WAKE;
    end else begin
      if (wr_clk) begin
        clk_q <= hwdata[7:0];
      end
      if (wr_rc) begin
        rc_q <= hwdata[7:0];
      end
      if (wr_xt) begin
        xt_q <= hwdata[7:0];
      end
      if (wr_wake) begin
        port_a_wake_enable <= hwdata[N_PA-1:0];
      end
    end
  end

  // Status flags: power-down and watchdog time-out.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_down_flag       <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end else begin
      if (halt_ok) begin
        power_down_flag <= 1'b1;
      end else if (clr_wdt_exec) begin
        power_down_flag <= 1'b0;
      end
      if (wdt_overflow) begin
        watchdog_timeout_flag <= 1'b1;
      end else if (halt_ok) begin
        watchdog_timeout_flag <= 1'b0;
      end
    end
  end

  // Stable flags restart low on enable; the RC flag also on frequency change.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_en_q                 <= 1'b0;
      xt_en_q                 <= 1'b0;
      internal_rc_stable_flag <= 1'b0;
      crystal_stable_flag     <= 1'b0;
    end else begin
      rc_en_q <= osc_en.fast_rc;
      xt_en_q <= osc_en.fast_xt;
      if (!osc_en.fast_rc || !rc_en_q || rc_fchg) begin
        internal_rc_stable_flag <= 1'b0;
      end else if (high_speed_rc_ready) begin
        internal_rc_stable_flag <= 1'b1;
      end
      if (!osc_en.fast_xt || !xt_en_q) begin
        crystal_stable_flag <= 1'b0;
      end else if (high_speed_crystal_ready) begin
        crystal_stable_flag <= 1'b1;
      end
    end
  end

  // Mode machine and registered outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q          <= OMP_FAST;
      sel_q           <= 3'h0;
      cause_q         <= OMP_WK_PIN;
      irq_pre_q       <= '0;
      irq_wk_q        <= '0;
      pa_q            <= '1;  // Pins idle high, so no false fall.
      osc_en          <= '0;
      cpu_ctl         <= '0;
      sys_clk_div_sel <= 3'h0;
      mode            <= OMP_FAST;
    end else begin
      mode_q          <= mode_d;
      sel_q           <= sel_d;
      cause_q         <= cause_d;
      pa_q            <= port_a_in;
      osc_en          <= osc_d;
      cpu_ctl         <= cpu_d;
      sys_clk_div_sel <= sel_d;
      mode            <= mode_d;
      if (halt_ok) begin
        irq_pre_q <= int_req;
      end
      if (wake) begin
        irq_wk_q <= irq_new;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_halt_pdf_set:  assert property (halt_ok |=> power_down_flag)
    else $error("halt did not set power-down flag");
  a_halt_to_clr:   assert property (halt_ok && !wdt_overflow
    |=> !watchdog_timeout_flag)
    else $error("halt did not clear time-out flag");
  a_halt_wdt_clr:  assert property (halt_ok |=> cpu_ctl.wdt_clear)
    else $error("halt did not clear watchdog");
  a_clrwdt_pdf:    assert property (clr_wdt_exec && !halt_ok
    |=> !power_down_flag)
    else $error("watchdog clear left power-down flag");
  a_sleep_osc_off: assert property (mode_q == OMP_SLEEP
    |-> osc_en == '0)
    else $error("oscillator running in sleep");
  a_slow_entry:    assert property ($rose(mode_q == OMP_SLOW) &&
    $past(mode_q) == OMP_SLOW_WAIT |-> $past(slow_stable))
    else $error("slow mode entered before stable");
  a_down_gated:    assert property (is_down(mode_q) |-> ##1
    !cpu_ctl.run)
    else $error("cpu clock open while powered down");
  a_wake_wait:     assert property (mode_q == OMP_WAKE && !sys_stable
    |=> mode_q == OMP_WAKE)
    else $error("left wake before oscillator stable");
  a_wdt_wake_to:   assert property (is_down(mode_q) && wdt_overflow
    |=> watchdog_timeout_flag ##1 cause_q == OMP_WK_WDT)
    else $error("overflow wake did not set time-out");
  a_pre_irq_quiet: assert property (mode_q == OMP_SLEEP &&
    !wk_pin && !wdt_overflow && int_req == irq_pre_q
    |=> mode_q == OMP_SLEEP)
    else $error("old request woke the device");

  c_sleep_pin:  cover property (mode_q == OMP_SLEEP ##1
                                mode_q == OMP_WAKE && cause_q == OMP_WK_PIN);
  c_irq_take:   cover property (cpu_ctl.int_take);
  c_slow_back:  cover property (mode_q == OMP_FAST_WAIT ##[1:50]
                                mode_q == OMP_FAST);
endmodule

// ### omp_osc_model.sv
// Behavioural model of the four oscillator cells beside the controller.
module omp_osc_model
  import omp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  omp_pkg::omp_osc_t osc_en,
  input  wire logic [3:0]  lat,
  output logic             high_speed_rc_ready,
  output logic             high_speed_crystal_ready,
  output logic             low_speed_rc_ready,
  output logic             low_speed_crystal_ready
);
  logic [3:0] en_w;      // Enables in struct order, fast RC first.
  logic [3:0] rdy_q;     // Ready levels in the same order.
  logic [3:0] cnt_q [4]; // Start-up counters, one per cell.

  assign en_w = osc_en;
  assign high_speed_rc_ready      = rdy_q[3];
  assign high_speed_crystal_ready = rdy_q[2];
  assign low_speed_rc_ready       = rdy_q[1];
  assign low_speed_crystal_ready  = rdy_q[0];

  // A cell that is stopped loses ready at once; a started cell needs lat + 1
  // cycles before it reports stable, so software must watch the flag.
  always_ff @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < 4; i++) begin
      if (!hresetn) begin
        cnt_q[i] <= 4'h0;
        rdy_q[i] <= 1'b0;
      end else if (!en_w[i]) begin
        cnt_q[i] <= 4'h0;
        rdy_q[i] <= 1'b0;
      end else if (cnt_q[i] >= lat) begin
        rdy_q[i] <= 1'b1;
      end else begin
        cnt_q[i] <= cnt_q[i] + 4'h1;
      end
    end
  end
endmodule

// ### operating_mode_power_control_tb.sv
// Self-checking bench for the operating mode and power controller.
module operating_mode_power_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import omp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, halt_exec, clr_wdt_exec;
  logic        wdt_overflow, stack_full, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sys_clk_div_sel;
  logic [7:0]  int_req, int_enable, port_a_in;
  logic [3:0]  lat;
  logic        hrc_rdy, hxt_rdy, lrc_rdy, lxt_rdy;
  omp_osc_t    osc_en;
  omp_cpu_t    cpu_ctl;
  omp_mode_t   mode;
  int          errors, cmp_count, seed, n_wclr, pin;

  // The single slave drives the bus ready.
  assign hready = hreadyout;

  omp_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .halt_exec(halt_exec),
    .clr_wdt_exec(clr_wdt_exec), .wdt_overflow(wdt_overflow),
    .int_req(int_req), .int_enable(int_enable), .stack_full(stack_full),
    .port_a_in(port_a_in), .high_speed_rc_ready(hrc_rdy),
    .high_speed_crystal_ready(hxt_rdy), .low_speed_rc_ready(lrc_rdy),
    .low_speed_crystal_ready(lxt_rdy), .osc_en(osc_en),
    .cpu_ctl(cpu_ctl), .sys_clk_div_sel(sys_clk_div_sel), .mode(mode));

  omp_osc_model i_osc (.hclk(hclk), .hresetn(hresetn), .osc_en(osc_en),
    .lat(lat), .high_speed_rc_ready(hrc_rdy),
    .high_speed_crystal_ready(hxt_rdy), .low_speed_rc_ready(lrc_rdy),
    .low_speed_crystal_ready(lxt_rdy));

  // Free-running 20 MHz clock.
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Counts watchdog clear strobes seen by the core.
  always @(posedge hclk) begin
    if (cpu_ctl.wdt_clear === 1'b1) begin
      n_wclr++;
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite word transfer; waits on ready in both phases.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    @(posedge hclk);
  endtask

  // Waits a bounded time for the controller to reach a mode.
  task automatic wait_mode(input omp_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 300) begin
      @(posedge hclk);
      n++;
    end
  endtask

  // Raises one of the core strobes for a single cycle.
  task automatic strobe(input int which);
    if (which == 0) halt_exec <= 1'b1;
    else if (which == 1) clr_wdt_exec <= 1'b1;
    else wdt_overflow <= 1'b1;
    @(posedge hclk);
    halt_exec    <= 1'b0;
    clr_wdt_exec <= 1'b0;
    wdt_overflow <= 1'b0;
    @(posedge hclk);
  endtask

  // Power-down mode expected for each pair of keep bits {fast, slow}.
  function automatic omp_mode_t exp_mode(input int k);
    case (k)
      0: exp_mode = OMP_SLEEP;
      1: exp_mode = OMP_STBY_SLOW;
      2: exp_mode = OMP_STBY_FAST;
      default: exp_mode = OMP_STBY_BOTH;
    endcase
  endfunction

  // Resume strobe {resume_next, int_take, pc_sp_reset} per wake case.
  function automatic logic [2:0] exp_wake(input int k);
    case (k)
      0: exp_wake = 3'h4;
      1: exp_wake = 3'h1;
      2: exp_wake = 3'h2;
      default: exp_wake = 3'h4;
    endcase
  endfunction

  // Bounded hang guard sized well above the planned sequence.
  initial begin
    repeat (30000) @(posedge hclk);
    errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    {hsel, hwrite, halt_exec, clr_wdt_exec, wdt_overflow} = 5'h00;
    {haddr, hwdata, htrans, hsize, stack_full} = '0;
    {int_req, int_enable} = 16'h0000;
    port_a_in = 8'hFF;
    errors = 0;
    cmp_count = 0;
    n_wclr = 0;
    seed = 34;
    lat = 4'h3;
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h00, 32'h0, rd);
    cmp(rd, 32'h0);
    bus(1'b0, 8'h14, 32'h0, rd);
    cmp(rd, 32'h0);
    // Slow and back to fast through every divider code.
    for (int n = 0; n < 7; n++) begin
      lat <= 4'h2 + 4'($random(seed) & 7);
      bus(1'b1, 8'h00, 32'hE0 | 32'(n[0]) << 2, rd);
      wait_mode(OMP_SLOW);
      cmp({29'h0, sys_clk_div_sel}, 32'h7);
      cmp({31'h0, osc_en.slow_xt}, 32'(n[0]));
      bus(1'b1, 8'h00, 32'(n) << 5, rd);
      wait_mode(OMP_FAST);
      cmp({29'h0, sys_clk_div_sel}, 32'(n));
      cmp({31'h0, hrc_rdy}, 32'h1);
    end
    // Halt with each pair of keep bits, then wake by each source.
    for (int k = 0; k < 4; k++) begin
      pin = $random(seed) & 7;
      int_enable <= 8'h01;
      stack_full <= (k == 3);
      int_req <= 8'h02;
      bus(1'b1, 8'h10, 32'h1 << pin, rd);
      bus(1'b1, 8'h00, 32'(k), rd);
      strobe(0);
      repeat (2) @(posedge hclk);
      cmp({28'h0, mode}, {28'h0, exp_mode(k)});
      cmp(32'(n_wclr), 32'(k + 1));
      bus(1'b0, 8'h0C, 32'h0, rd);
      cmp(rd & 32'h3, 32'h2);
      // Disabled pin and an old request must not wake the core.
      port_a_in <= ~(8'h1 << ((pin + 1) & 7));
      repeat (10) @(posedge hclk);
      cmp({28'h0, mode}, {28'h0, exp_mode(k)});
      port_a_in <= (k == 0) ? ~(8'h1 << pin) : 8'hFF;
      if (k == 1) strobe(2);
      else if (k == 0) @(posedge hclk);
      else int_req <= 8'h03;
      for (int n = 0; n < 300; n++) begin
        @(posedge hclk);
        if ((cpu_ctl.resume_next | cpu_ctl.int_take
             | cpu_ctl.pc_sp_reset) === 1'b1) break;
      end
      cmp({29'h0, cpu_ctl.resume_next, cpu_ctl.int_take,
           cpu_ctl.pc_sp_reset}, 32'(exp_wake(k)));
      cmp({30'h0, cpu_ctl.run, hrc_rdy}, 32'h3);
      port_a_in <= 8'hFF;
      int_req <= 8'h00;
      bus(1'b0, 8'h0C, 32'h0, rd);
      cmp(rd & 32'h73, (k == 1) ? 32'h3 : 32'h2);
    end
    strobe(1);
    bus(1'b0, 8'h0C, 32'h0, rd);
    cmp(rd & 32'h2, 32'h0);
    summarize();
  end
endmodule
